// ### rtl/adps_pin_mux.sv
// Pin function select for port C address pins 8..0 and port D data pins 15..0.
// Assumes an APB4 master on clk_sys, op_mode held static by the system,
// and an external pad that resolves pin level from output and low enable.
//
// Overview of operation
// - Port C mode bit one selects address output, zero selects general I/O.
// - ROM disabled: port C pin is address output regardless of its bit.
// - Single-chip: port C pin stays general I/O regardless of its bit.
// - Port C mode bits reset to zero.
// - Port D direction register, sixteen read/write bits, reset zero, byte lanes.
// - Port D control register, sixteen read/write mode bits, reset zero, byte lanes.
// - Port D mode bit one selects data bus line, zero selects general I/O.
// - ROM disabled: port D pin is data bus line regardless of its bit.
// - Single-chip: port D pin stays general I/O regardless of its bit.
// - Port D mode bits reset to zero.
//
// Register access over APB was chosen for this implementation.
module adps_pin_mux
   import adps_pkg::*;
#(
   parameter int unsigned PC_PINS = ADPS_PC_PINS,
   parameter int unsigned PD_PINS = ADPS_PD_PINS
) (
   input  logic                   clk_sys,
   input  logic                   rst_n,
   input  logic                   psel,
   input  logic                   penable,
   input  logic                   pwrite,
   input  logic [ADPS_ADDR_W-1:0] paddr,
   input  logic [31:0]            pwdata,
   input  logic [3:0]             pstrb,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  logic [1:0]             op_mode,
   input  logic [PC_PINS-1:0]     ext_addr,
   input  logic [PD_PINS-1:0]     ext_data_out,
   input  logic                   ext_data_oe,
   output logic [PD_PINS-1:0]     ext_data_in,
   input  logic [PC_PINS-1:0]     gpio_c_out,
   input  logic [PC_PINS-1:0]     gpio_c_dir,
   output logic [PC_PINS-1:0]     gpio_c_in,
   input  logic [PD_PINS-1:0]     gpio_d_out,
   output logic [PD_PINS-1:0]     gpio_d_in,
   input  logic [PC_PINS-1:0]     pin_c_i,
   output logic [PC_PINS-1:0]     pin_c_o,
   output logic [PC_PINS-1:0]     pin_c_oe_n,
   input  logic [PD_PINS-1:0]     pin_d_i,
   output logic [PD_PINS-1:0]     pin_d_o,
   output logic [PD_PINS-1:0]     pin_d_oe_n
);

   typedef struct packed {
      logic [PD_PINS-1:0] dir_d;
      logic [PD_PINS-1:0] func_d;
      logic [PC_PINS-1:0] func_c;
      logic [31:0]        rdata;
      logic [PC_PINS-1:0] c_o;
      logic [PC_PINS-1:0] c_oe_n;
      logic [PC_PINS-1:0] c_in;
      logic [PD_PINS-1:0] d_o;
      logic [PD_PINS-1:0] d_oe_n;
      logic [PD_PINS-1:0] d_ext_in;
      logic [PD_PINS-1:0] d_gpio_in;
   } adps_state_type;

   adps_state_type state_ff;
   adps_state_type nxt_state;

   logic               rom_off;
   logic               single;
   logic [PC_PINS-1:0] eff_c;
   logic [PD_PINS-1:0] eff_d;
   logic [PC_PINS-1:0] mux_c_o;
   logic [PC_PINS-1:0] mux_c_oe_n;
   logic [PD_PINS-1:0] mux_d_o;
   logic [PD_PINS-1:0] mux_d_oe_n;
   logic               setup;
   logic               wr_acc;
   logic               hit_dir;
   logic               hit_fd;
   logic               hit_fc;
   logic               hit_st;
   logic               mapped;
   logic [31:0]        stat_word;

   assign rom_off = (op_mode == ADPS_OPM_ROM_OFF);
   assign single  = (op_mode == ADPS_OPM_SINGLE);

   // One mux per pin; port C uses only the low pins
   for (genvar i = 0; i < PD_PINS; i++) begin : g_pin
      // Single-chip beats the mode bit, ROM-off forces bus use
      assign eff_d[i] = single ? 1'b0 : (rom_off ? 1'b1 : state_ff.func_d[i]);
      assign mux_d_o[i] = eff_d[i] ? ext_data_out[i] : gpio_d_out[i];
      assign mux_d_oe_n[i] = eff_d[i] ? ~ext_data_oe : ~state_ff.dir_d[i];
      if (i < PC_PINS) begin : g_c
         assign eff_c[i] = single ? 1'b0 : (rom_off ? 1'b1 : state_ff.func_c[i]);
         assign mux_c_o[i] = eff_c[i] ? ext_addr[i] : gpio_c_out[i];
         // Address lines are always driven; GPIO direction comes from port C logic
         assign mux_c_oe_n[i] = eff_c[i] ? 1'b0 : ~gpio_c_dir[i];
      end
   end

   assign setup   = psel & ~penable;
   assign wr_acc  = psel & penable & pwrite;
   assign hit_dir = (paddr == ADPS_ADDR_PD_DIR);
   assign hit_fd  = (paddr == ADPS_ADDR_PD_FUNC);
   assign hit_fc  = (paddr == ADPS_ADDR_PC_FUNC);
   assign hit_st  = (paddr == ADPS_ADDR_FUNC_STAT);
   assign mapped  = hit_dir | hit_fd | hit_fc | hit_st;

   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[ADPS_STAT_PC_LSB +: PC_PINS] = eff_c;
      stat_word[ADPS_STAT_PD_LSB +: PD_PINS] = eff_d;
   end

   // Byte-lane merge; 8, 16 and 32-bit writes all land through pstrb
   function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                              input logic [31:0] wd,
                                              input logic [3:0]  st);
      logic [15:0] r;
      r = old_v;
      if (st[0]) begin
         r[7:0] = wd[7:0];
      end
      if (st[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   always_comb begin
      logic [15:0] fc_wide;
      fc_wide = 16'h0000;
      nxt_state = state_ff;
      nxt_state.c_o       = mux_c_o;
      nxt_state.c_oe_n    = mux_c_oe_n;
      nxt_state.d_o       = mux_d_o;
      nxt_state.d_oe_n    = mux_d_oe_n;
      nxt_state.c_in      = pin_c_i & ~eff_c;
      nxt_state.d_ext_in  = pin_d_i & eff_d;
      nxt_state.d_gpio_in = pin_d_i & ~eff_d;
      // Read data is loaded in setup so it stands from a flop in access
      if (setup & ~pwrite) begin
         nxt_state.rdata = 32'h0000_0000;
         if (hit_dir) begin
            nxt_state.rdata[PD_PINS-1:0] = state_ff.dir_d;
         end
         if (hit_fd) begin
            nxt_state.rdata[PD_PINS-1:0] = state_ff.func_d;
         end
         if (hit_fc) begin
            nxt_state.rdata[PC_PINS-1:0] = state_ff.func_c;
         end
         if (hit_st) begin
            nxt_state.rdata = stat_word;
         end
      end
      if (wr_acc & hit_dir) begin
         nxt_state.dir_d = lane_merge(state_ff.dir_d, pwdata, pstrb);
      end
      if (wr_acc & hit_fd) begin
         nxt_state.func_d = lane_merge(state_ff.func_d, pwdata, pstrb);
      end
      if (wr_acc & hit_fc) begin
         fc_wide = lane_merge(16'(state_ff.func_c), pwdata, pstrb);
         nxt_state.func_c = fc_wide[PC_PINS-1:0];
      end
      if (!rst_n) begin
         nxt_state = '0;
         nxt_state.dir_d  = ADPS_RST_PD_DIR;
         nxt_state.func_d = ADPS_RST_PD_FUNC;
         nxt_state.func_c = ADPS_RST_PC_FUNC;
         // Pins float until the first mux result is registered
         nxt_state.c_oe_n = '1;
         nxt_state.d_oe_n = '1;
      end
   end

   always_ff @(posedge clk_sys) begin
      state_ff <= nxt_state;
   end

   assign pready      = 1'b1;
   assign pslverr     = psel & penable & ~mapped;
   assign prdata      = state_ff.rdata;
   assign pin_c_o     = state_ff.c_o;
   assign pin_c_oe_n  = state_ff.c_oe_n;
   assign pin_d_o     = state_ff.d_o;
   assign pin_d_oe_n  = state_ff.d_oe_n;
   assign gpio_c_in   = state_ff.c_in;
   assign ext_data_in = state_ff.d_ext_in;
   assign gpio_d_in   = state_ff.d_gpio_in;

   sequence s_dir_write;
      psel && penable && pwrite && hit_dir && (pstrb[1:0] == 2'b11);
   endsequence

   sequence s_fd_write;
      psel && penable && pwrite && hit_fd && (pstrb[1:0] == 2'b11);
   endsequence

   sequence s_fc_write;
      psel && penable && pwrite && hit_fc && (pstrb[1:0] == 2'b11);
   endsequence

   sequence s_rd_setup;
      psel && !penable && !pwrite;
   endsequence

   a_c_mode_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_mode == ADPS_OPM_ROM_ON) |=> pin_c_o == $past((state_ff.func_c & ext_addr) | (~state_ff.func_c & gpio_c_out)))
      else $error("Port C pin not routed by its mode bit");

   a_c_romoff_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_mode == ADPS_OPM_ROM_OFF) |=> (pin_c_oe_n == '0) && (pin_c_o == $past(ext_addr)))
      else $error("Port C not address output with ROM disabled");

   a_c_single_gpio: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_mode == ADPS_OPM_SINGLE) |=> (pin_c_o == $past(gpio_c_out)) && (pin_c_oe_n == ~$past(gpio_c_dir)))
      else $error("Port C not general I/O in single-chip");

   a_mode_reset: assert property (@(posedge clk_sys)
      $rose(rst_n) |-> (state_ff.func_c == '0) && (state_ff.func_d == '0) && (state_ff.dir_d == '0))
      else $error("Mode or direction bits not zero after reset");

   a_dir_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_dir_write |=> state_ff.dir_d == $past(pwdata[15:0]))
      else $error("Port D direction write lost");

   a_func_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_fd_write |=> state_ff.func_d == $past(pwdata[15:0]))
      else $error("Port D control write lost");

   a_func_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_rd_setup ##0 hit_fd |=> prdata[15:0] == $past(state_ff.func_d))
      else $error("Port D control readback wrong");

   a_dir_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_rd_setup ##0 hit_dir |=> prdata[15:0] == $past(state_ff.dir_d))
      else $error("Port D direction readback wrong");

   a_read_upper: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_rd_setup ##0 (hit_dir || hit_fd || hit_fc) |=> prdata[31:16] == '0)
      else $error("Upper read bits not zero");

   a_pc_func_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_fc_write |=> state_ff.func_c == $past(pwdata[PC_PINS-1:0]))
      else $error("Port C mode write lost");

   a_dir_low_lane: assert property (@(posedge clk_sys) disable iff (!rst_n)
      psel && penable && pwrite && hit_dir && (pstrb[1:0] == 2'b01)
      |=> state_ff.dir_d == {$past(state_ff.dir_d[15:8]), $past(pwdata[7:0])})
      else $error("Port D direction low byte write wrong");

   a_dir_high_lane: assert property (@(posedge clk_sys) disable iff (!rst_n)
      psel && penable && pwrite && hit_dir && (pstrb[1:0] == 2'b10)
      |=> state_ff.dir_d == {$past(pwdata[15:8]), $past(state_ff.dir_d[7:0])})
      else $error("Port D direction high byte write wrong");

   a_ready_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
      psel && penable |-> pready)
      else $error("Register access not answered at once");

   a_err_mapped: assert property (@(posedge clk_sys) disable iff (!rst_n)
      psel && penable && mapped |-> !pslverr)
      else $error("Error flagged on a mapped register");

   a_err_unmapped: assert property (@(posedge clk_sys) disable iff (!rst_n)
      psel && penable && !mapped |-> pslverr)
      else $error("Unmapped access not flagged");

   a_c_gpio_in: assert property (@(posedge clk_sys) disable iff (!rst_n)
      1'b1 |=> (gpio_c_in & $past(eff_c)) == '0)
      else $error("Port C address pin leaks into general input");

   a_d_ext_in: assert property (@(posedge clk_sys) disable iff (!rst_n)
      1'b1 |=> (ext_data_in & ~$past(eff_d)) == '0)
      else $error("Port D general pin leaks into bus data");

   a_d_gpio_in: assert property (@(posedge clk_sys) disable iff (!rst_n)
      1'b1 |=> (gpio_d_in & $past(eff_d)) == '0)
      else $error("Port D bus pin leaks into general input");

   a_pins_reset: assert property (@(posedge clk_sys)
      !rst_n |=> (pin_c_oe_n == '1) && (pin_d_oe_n == '1))
      else $error("Pins driven during reset");

   a_d_single_oe: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_mode == ADPS_OPM_SINGLE) |=> pin_d_oe_n == ~$past(state_ff.dir_d))
      else $error("Port D enable not from direction in single-chip");

   a_d_mode_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_mode == ADPS_OPM_ROM_ON) |=> pin_d_o == $past((state_ff.func_d & ext_data_out) | (~state_ff.func_d & gpio_d_out)))
      else $error("Port D pin not routed by its mode bit");

   a_d_romoff_bus: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_mode == ADPS_OPM_ROM_OFF) ##0 !ext_data_oe |=> (pin_d_oe_n == '1) && (ext_data_in == $past(pin_d_i)))
      else $error("Port D not data bus with ROM disabled");

   a_d_single_gpio: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_mode == ADPS_OPM_SINGLE) |=> (pin_d_o == $past(gpio_d_out)) && (ext_data_in == '0))
      else $error("Port D not general I/O in single-chip");

   a_gpio_dir_oe: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (op_mode != ADPS_OPM_ROM_OFF) |=> ($past(~eff_d) & (pin_d_oe_n ^ ~$past(state_ff.dir_d))) == '0)
      else $error("GPIO output enable does not follow direction");

endmodule

// ### rtl/adps_pkg.sv
// Constants for the address/data pin function select block.
// Assumes an APB slave window decoded on the low 16 address bits.
package adps_pkg;
   localparam int unsigned ADPS_ADDR_W   = 16;
   localparam int unsigned ADPS_PC_PINS  = 9;
   localparam int unsigned ADPS_PD_PINS  = 16;

   // Printed register offsets are kept as indices; byte address is four times
   localparam logic [31:0] ADPS_IDX_PD_DIR    = 32'hffff83a6;
   localparam logic [31:0] ADPS_IDX_PD_FUNC   = 32'hffff83ac;
   localparam logic [31:0] ADPS_IDX_PC_FUNC   = 32'hffff83b0;
   localparam logic [31:0] ADPS_IDX_FUNC_STAT = 32'hffff83b1;

   localparam logic [15:0] ADPS_ADDR_PD_DIR    = 16'(ADPS_IDX_PD_DIR << 2);
   localparam logic [15:0] ADPS_ADDR_PD_FUNC   = 16'(ADPS_IDX_PD_FUNC << 2);
   localparam logic [15:0] ADPS_ADDR_PC_FUNC   = 16'(ADPS_IDX_PC_FUNC << 2);
   localparam logic [15:0] ADPS_ADDR_FUNC_STAT = 16'(ADPS_IDX_FUNC_STAT << 2);

   localparam logic [15:0] ADPS_RST_PD_DIR  = 16'h0000;
   localparam logic [15:0] ADPS_RST_PD_FUNC = 16'h0000;
   localparam logic [8:0]  ADPS_RST_PC_FUNC = 9'h000;

   // Status word layout
   localparam int unsigned ADPS_STAT_PC_LSB = 0;
   localparam int unsigned ADPS_STAT_PD_LSB = 16;

   typedef enum logic [1:0] {
      ADPS_OPM_ROM_ON  = 2'b00,
      ADPS_OPM_ROM_OFF = 2'b01,
      ADPS_OPM_SINGLE  = 2'b10
   } adps_op_mode_type;
endpackage

// ### tb/adps_bus_dev.sv
// Far-side pad model: external bus device on port C and D pins.
// Assumes oe_n low means the block drives the pad; no pull resistors.
module adps_bus_dev (
   input  logic        clk_sys,
   input  logic        drv_en,
   input  logic [15:0] drv_val,
   input  logic [8:0]  pin_c_o,
   input  logic [8:0]  pin_c_oe_n,
   input  logic [15:0] pin_d_o,
   input  logic [15:0] pin_d_oe_n,
   output logic [8:0]  pin_c_i,
   output logic [15:0] pin_d_i
);
   logic [8:0]  last_c_ff = '0;
   logic [15:0] last_d_ff = '0;
   // Floating pads toggle so a stale level is never mistaken for data
   always_comb begin
      pin_c_i = (pin_c_o & ~pin_c_oe_n) | (~last_c_ff & pin_c_oe_n);
      pin_d_i = (pin_d_o & ~pin_d_oe_n) | ((drv_en ? drv_val : ~last_d_ff) & pin_d_oe_n);
   end
   always_ff @(posedge clk_sys) begin
      last_c_ff <= pin_c_i;
      last_d_ff <= pin_d_i;
   end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the address/data pin function select block.
// Assumes zero-wait APB and a one-cycle pin pipeline.
module testbench
   import adps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [1:0] op; logic [8:0] pcf; logic [15:0] pdf, pdd;
      logic [8:0] c_o, c_oe_n; logic [15:0] d_o, d_oe_n;
   } adps_row_type;
   logic        clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, ext_data_oe = 1, drv_en = 0;
   logic [15:0] paddr = '0, ext_data_out = 16'h1234, gpio_d_out = 16'hbeef, drv_val = 16'h5a3c;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0]  pstrb = 4'hf;
   logic [1:0]  op_mode = 2'b00;
   logic [8:0]  ext_addr = 9'h1a5, gpio_c_out = 9'h05a, gpio_c_dir = 9'h0f0, pin_c_i, pin_c_o, pin_c_oe_n, gpio_c_in;
   logic [15:0] ext_data_in, gpio_d_in, pin_d_i, pin_d_o, pin_d_oe_n;
   logic        pready, pslverr, err;
   int          mismatches = 0, comparisons = 0, cycles = 0;
   adps_row_type rows [5] = '{
      '{2'b00, 9'h000, 16'h0000, 16'h0000, 9'h05a, 9'h10f, 16'hbeef, 16'hffff},
      '{2'b00, 9'h0ff, 16'hff00, 16'h00f0, 9'h0a5, 9'h100, 16'h12ef, 16'h000f},
      '{2'b01, 9'h000, 16'h0000, 16'h00f0, 9'h1a5, 9'h000, 16'h1234, 16'h0000},
      '{2'b10, 9'h1ff, 16'hffff, 16'h0f0f, 9'h05a, 9'h10f, 16'hbeef, 16'hf0f0},
      '{2'b11, 9'h100, 16'h0001, 16'h0000, 9'h15a, 9'h00f, 16'hbeee, 16'hfffe}};

   adps_pin_mux i_adps_pin_mux (.*);
   adps_bus_dev i_adps_bus_dev (.*);

   always #2.5 clk_sys = ~clk_sys;
   // Whole run needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         results();
      end
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle();
      @(posedge clk_sys);
      #1;
   endtask
   task automatic regs_zero();
      apb(1'b0, ADPS_ADDR_PD_DIR, '0, 4'h0);
      chk("port_d_direction_low", rd, 32'h0);
      chk("pslverr", err, 32'h0);
      chk("pready", pready, 32'h1);
      apb(1'b0, ADPS_ADDR_PD_FUNC, '0, 4'h0);
      chk("port_d_function_low", rd, 32'h0);
      apb(1'b0, ADPS_ADDR_PC_FUNC, '0, 4'h0);
      chk("port_c_function", rd, 32'h0);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      regs_zero();
      foreach (rows[i]) begin
         op_mode <= rows[i].op;
         apb(1'b1, ADPS_ADDR_PC_FUNC, 32'(rows[i].pcf), 4'h3);
         apb(1'b1, ADPS_ADDR_PD_FUNC, 32'(rows[i].pdf), 4'h3);
         apb(1'b1, ADPS_ADDR_PD_DIR, 32'(rows[i].pdd), 4'h3);
         settle();
         chk("pin_c_o", pin_c_o, rows[i].c_o);
         chk("pin_c_oe_n", pin_c_oe_n, rows[i].c_oe_n);
         chk("pin_d_o", pin_d_o, rows[i].d_o);
         chk("pin_d_oe_n", pin_d_oe_n, rows[i].d_oe_n);
      end
      op_mode <= 2'b10;
      settle();
      settle();
      settle();
      chk("gpio_c_in", 32'(gpio_c_in & gpio_c_dir), 32'h050);
      chk("ext_data_in", ext_data_in, 32'h0);
      // Byte lanes: each strobe touches its own half only
      apb(1'b1, ADPS_ADDR_PD_DIR, 32'hffffa5c3, 4'h1);
      apb(1'b1, ADPS_ADDR_PD_DIR, 32'h00007e00, 4'h2);
      apb(1'b0, ADPS_ADDR_PD_DIR, '0, 4'h0);
      chk("port_d_direction_low", rd, 32'h00007ec3);
      apb(1'b1, ADPS_ADDR_PD_FUNC, 32'hffffffff, 4'hf);
      apb(1'b0, ADPS_ADDR_PD_FUNC, '0, 4'h0);
      chk("port_d_function_low", rd, 32'h0000ffff);
      apb(1'b0, 16'h0ea0, '0, 4'h0);
      chk("pslverr", err, 32'h1);
      chk("prdata", rd, 32'h0);
      op_mode <= 2'b01;
      ext_data_oe <= 1'b0;
      drv_en <= 1'b1;
      repeat (2) @(posedge clk_sys);
      settle();
      chk("pin_d_oe_n", pin_d_oe_n, 32'hffff);
      chk("ext_data_in", ext_data_in, 32'h5a3c);
      chk("gpio_d_in", gpio_d_in, 32'h0);
      apb(1'b0, ADPS_ADDR_FUNC_STAT, '0, 4'h0);
      chk("function_status", rd, 32'hffff01ff);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      regs_zero();
      results();
   end
endmodule
